// *** design/io_cell.sv ***
// io cell: pad input capture (bypass/sdr/ddr/memory/gearbox) and output register
//
// Function
// - bypass path: pad straight to comb_in, bypass_clk
// - optional fixed delay; bottom edge may replace it with dyn_delay
// - sdr: one register captures on sys_clk
// - ddr: rise and fall sys_clk registers
// - cap_rise rising data; cap_fall sdr or falling
// - memory mode samples both read_strobe_90 edges
// - strobe streams re-registered into sys_clk domain
// - sync_clk_polarity picks sync register clock edge
// - strobe inputs and memory mode right edge only
// - gearbox stage one: both fast edge clock edges
// - gearbox stage two: align on update, align_select
// - gearbox stage three: registered on slow sys_clk
// - out_d_a/out_d_b drive pad_out; tri_in to pad_oe
// - capture/output registers gated by enable and forced by set/reset; write_strobe_seen_o only by set/reset
`timescale 1ns/100ps
module io_cell
   import io_cell_pkg::*;
#(
   parameter io_cell_pkg::cell_edge_t CELL_EDGE = io_cell_pkg::EDGE_RIGHT
) (
   input  wire logic                              mclk_i,
   input  wire logic                              reset_i,
   input  wire logic                              pad_i,
   input  wire logic                              sys_clk_i,
   input  wire logic                              edge_clk_i,
   input  wire logic                              read_strobe_90_i,
   input  wire logic                              write_strobe_90_i,
   input  wire logic                              sync_clk_polarity_i,
   input  wire io_cell_pkg::cell_cfg_t            cfg_i,
   input  wire logic                              cell_ce_i,
   input  wire logic                              lsr_i,
   input  wire logic                              update_i,
   input  wire logic                              align_select_i,
   input  wire logic                              out_d_a_i,
   input  wire logic                              out_d_b_i,
   input  wire logic                              tri_in_i,
   output logic                                   comb_in_o,
   output logic                                   bypass_clk_o,
   output logic                                   cap_rise_o,
   output logic                                   cap_fall_o,
   output logic [io_cell_pkg::GEAR_W-1:0]         gear_data_o,
   output logic                                   pad_out_o,
   output logic                                   pad_oe_o,
   output logic                                   write_strobe_seen_o
);

   import io_cell_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // bypass and synchronisers

   // the bypass is meant to be raw; it never touches a register
   assign comb_in_o    = pad_i;
   assign bypass_clk_o = pad_i;

   logic [SY_W-1:0] async_bus;
   logic [SY_W-1:0] sync_bus;
   logic [SY_W-1:0] prev_ff;

   always_comb begin
      async_bus          = '0;
      async_bus[SY_PAD]  = pad_i;
      async_bus[SY_SCLK] = sys_clk_i;
      async_bus[SY_ECLK] = edge_clk_i;
      // strobe pins are only wired up on the right edge
      if (CELL_EDGE == EDGE_RIGHT) begin
         async_bus[SY_RSTB] = read_strobe_90_i;
         async_bus[SY_WSTB] = write_strobe_90_i;
         async_bus[SY_POL]  = sync_clk_polarity_i;
      end
   end

   sync2 #(
      .W (SY_W)
   ) u_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (async_bus),
      .sync_o  (sync_bus)
   );

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= sync_bus;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic rstb_rise;
   logic rstb_fall;
   logic eclk_rise;
   logic eclk_fall;
   logic wstb_rise;

   assign sclk_rise = sync_bus[SY_SCLK] & ~prev_ff[SY_SCLK];
   assign sclk_fall = ~sync_bus[SY_SCLK] & prev_ff[SY_SCLK];
   assign rstb_rise = sync_bus[SY_RSTB] & ~prev_ff[SY_RSTB];
   assign rstb_fall = ~sync_bus[SY_RSTB] & prev_ff[SY_RSTB];
   assign eclk_rise = sync_bus[SY_ECLK] & ~prev_ff[SY_ECLK];
   assign eclk_fall = ~sync_bus[SY_ECLK] & prev_ff[SY_ECLK];
   assign wstb_rise = sync_bus[SY_WSTB] & ~prev_ff[SY_WSTB];

   ////////////////////////////////////////////////////////////////////////////////
   // effective mode and input delay

   in_mode_t         mode_eff;
   logic [DLY_W-1:0] tap;

   always_comb begin
      mode_eff = cfg_i.mode;
      // memory mode elsewhere falls back to plain sdr capture
      if (cfg_i.mode == MODE_MEM && CELL_EDGE != EDGE_RIGHT) begin
         mode_eff = MODE_SDR;
      end
   end

   always_comb begin
      tap = TAP_NONE;
      if (cfg_i.delay_en) begin
         if (cfg_i.dyn_en && CELL_EDGE == EDGE_BOTTOM) begin
            tap = cfg_i.dyn_delay;
         end else begin
            tap = FIXED_TAP;
         end
      end
   end

   // delay modelled in whole mclk cycles; resolution is one period
   logic [DLY_DEPTH-1:0] dly_ff;
   logic                 din;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         dly_ff <= '0;
      end else begin
         dly_ff <= {dly_ff[DLY_DEPTH-2:0], sync_bus[SY_PAD]};
      end
   end

   assign din = (tap == TAP_NONE) ? sync_bus[SY_PAD] : dly_ff[tap - 5'h01];

   logic cap_en;
   assign cap_en = cell_ce_i & ~lsr_i;

   ////////////////////////////////////////////////////////////////////////////////
   // generic ddr capture on sys_clk rise and fall

   pair_t ddr_ff;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ddr_ff <= PAIR_RST;
      end else if (lsr_i) begin
         ddr_ff <= PAIR_RST;
      end else if (cell_ce_i) begin
         if (sclk_rise) begin
            ddr_ff.rise <= din;
         end
         if (sclk_fall) begin
            ddr_ff.fall <= din;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // memory mode: strobe capture and resync to sys_clk

   pair_t mem_ff;
   pair_t msync_ff;
   logic  sync_edge;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mem_ff <= PAIR_RST;
      end else if (lsr_i) begin
         mem_ff <= PAIR_RST;
      end else if (cell_ce_i && CELL_EDGE == EDGE_RIGHT) begin
         if (rstb_rise) begin
            mem_ff.rise <= din;
         end
         if (rstb_fall) begin
            mem_ff.fall <= din;
         end
      end
   end

   // choosing the edge keeps the strobe data away from its own changes
   assign sync_edge = (sync_bus[SY_POL] == POL_RISE) ? sclk_rise : sclk_fall;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         msync_ff <= PAIR_RST;
      end else if (lsr_i) begin
         msync_ff <= PAIR_RST;
      end else if (cell_ce_i && sync_edge) begin
         msync_ff <= mem_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // input gearbox

   pair_t                 g1_ff;
   logic [GEAR_HIST-1:0]  hist_ff;
   logic [GEAR_W-1:0]     g2_ff;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         g1_ff   <= PAIR_RST;
         hist_ff <= '0;
      end else if (lsr_i) begin
         g1_ff   <= PAIR_RST;
         hist_ff <= '0;
      end else if (cap_en && mode_eff == MODE_GEAR) begin
         if (eclk_rise) begin
            g1_ff.rise <= din;
         end
         if (eclk_fall) begin
            g1_ff.fall <= din;
            hist_ff    <= {hist_ff[GEAR_HIST-3:0], g1_ff.rise, din};
         end
      end
   end

   // align_select slides the window by one sample to fix the word boundary
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         g2_ff <= '0;
      end else if (lsr_i) begin
         g2_ff <= '0;
      end else if (cell_ce_i && update_i) begin
         if (align_select_i) begin
            g2_ff <= hist_ff[GEAR_HIST-1:1];
         end else begin
            g2_ff <= hist_ff[GEAR_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         gear_data_o <= '0;
      end else if (lsr_i) begin
         gear_data_o <= '0;
      end else if (cell_ce_i && sclk_rise) begin
         gear_data_o <= g2_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // core-facing capture outputs

   pair_t nxt_cap;

   always_comb begin
      nxt_cap = '{rise: cap_rise_o, fall: cap_fall_o};
      case (mode_eff)
         MODE_SDR: begin
            nxt_cap.rise = RST_BIT;
            nxt_cap.fall = din;
         end
         MODE_DDR: begin
            nxt_cap = ddr_ff;
         end
         MODE_MEM: begin
            nxt_cap = msync_ff;
         end
         MODE_BYPASS,
         MODE_GEAR: begin
            nxt_cap = PAIR_RST;
         end
         default: begin
            nxt_cap = PAIR_RST;
         end
      endcase
   end

   // the single sdr register is cap_fall_o itself, so it loads on the same edge
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cap_rise_o <= RST_BIT;
         cap_fall_o <= RST_BIT;
      end else if (lsr_i) begin
         cap_rise_o <= RST_BIT;
         cap_fall_o <= RST_BIT;
      end else if (cell_ce_i && sclk_rise) begin
         cap_rise_o <= nxt_cap.rise;
         cap_fall_o <= nxt_cap.fall;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output and tri-state registers

   logic out_ddr;
   assign out_ddr = (mode_eff == MODE_DDR) || (mode_eff == MODE_MEM);

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pad_out_o <= RST_BIT;
         pad_oe_o  <= RST_BIT;
      end else if (lsr_i) begin
         pad_out_o <= RST_BIT;
         pad_oe_o  <= RST_BIT;
      end else if (cell_ce_i) begin
         if (sclk_rise) begin
            pad_out_o <= out_d_a_i;
            pad_oe_o  <= ~tri_in_i;
         end else if (sclk_fall && out_ddr) begin
            pad_out_o <= out_d_b_i;
         end
      end
   end

   // write strobe only reports activity; the output path runs on sys_clk
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         write_strobe_seen_o <= RST_BIT;
      end else if (lsr_i) begin
         write_strobe_seen_o <= RST_BIT;
      end else if (wstb_rise) begin
         write_strobe_seen_o <= 1'b1;
      end
   end

endmodule

// *** design/io_cell_pkg.sv ***
// shared types and constants for the io cell input/output path
package io_cell_pkg;

   // capture modes of the input path
   typedef enum logic [2:0] {
      MODE_BYPASS,
      MODE_SDR,
      MODE_DDR,
      MODE_MEM,
      MODE_GEAR
   } in_mode_t;

   // which die edge the cell sits on; decides which features exist
   typedef enum logic [1:0] {
      EDGE_LEFT,
      EDGE_TOP,
      EDGE_BOTTOM,
      EDGE_RIGHT
   } cell_edge_t;

   localparam int DLY_W         = 5;
   localparam int DLY_DEPTH     = 32;
   localparam int CLK_PERIOD_NS = 20;
   // fixed input delay, in ns; the count of mclk cycles derives from it
   localparam int FIXED_DELAY_NS  = 60;
   localparam int FIXED_DELAY_CYC = (FIXED_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DLY_W-1:0] FIXED_TAP = DLY_W'(FIXED_DELAY_CYC);
   localparam logic [DLY_W-1:0] TAP_NONE  = 5'h00;

   // gearbox word: four samples per slow clock period
   localparam int GEAR_W    = 4;
   localparam int GEAR_HIST = GEAR_W + 1;

   // positions in the synchroniser bundle
   localparam int SY_PAD  = 0;
   localparam int SY_SCLK = 1;
   localparam int SY_RSTB = 2;
   localparam int SY_WSTB = 3;
   localparam int SY_ECLK = 4;
   localparam int SY_POL  = 5;
   localparam int SY_W    = 6;

   localparam logic RST_BIT = 1'b0;
   localparam logic POL_RISE = 1'b0;

   // static configuration of the input path
   typedef struct packed {
      in_mode_t         mode;
      logic             delay_en;
      logic             dyn_en;
      logic [DLY_W-1:0] dyn_delay;
   } cell_cfg_t;

   // one rising-edge sample and one falling-edge sample
   typedef struct packed {
      logic rise;
      logic fall;
   } pair_t;

   localparam pair_t PAIR_RST = '{rise: 1'b0, fall: 1'b0};

endpackage

// *** design/sync2.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;

   // meta_ff feeds sync_o and nothing else
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         sync_o  <= '0;
      end else begin
         meta_ff <= async_i;
         sync_o  <= meta_ff;
      end
   end

endmodule

// *** verification/io_cell_sva.sv ***
// concurrent checks on the io cell ports
`timescale 1ns/100ps
module io_cell_sva
   import io_cell_pkg::*;
(
   input wire logic                           mclk_i,
   input wire logic                           reset_i,
   input wire logic                           pad_i,
   input wire logic                           sys_clk_i,
   input wire io_cell_pkg::cell_cfg_t         cfg_i,
   input wire logic                           cell_ce_i,
   input wire logic                           lsr_i,
   input wire logic                           out_d_a_i,
   input wire logic                           out_d_b_i,
   input wire logic                           tri_in_i,
   input wire logic                           comb_in_o,
   input wire logic                           bypass_clk_o,
   input wire logic                           cap_rise_o,
   input wire logic                           cap_fall_o,
   input wire logic [io_cell_pkg::GEAR_W-1:0] gear_data_o,
   input wire logic                           pad_out_o,
   input wire logic                           pad_oe_o,
   input wire logic                           write_strobe_seen_o
);
   wire run_ok = cell_ce_i && !lsr_i;
   wire ddr_on = cfg_i.mode == MODE_DDR;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   ////////////////////////////////////////////////////////////////////////////////
   a_comb_follows: assert property (comb_in_o == pad_i)
      else $error("comb_in does not follow the pad");
   a_inclk_follows: assert property (bypass_clk_o == pad_i)
      else $error("bypass_clk does not follow the pad");
   a_lsr_clears: assert property (lsr_i |=> !cap_rise_o && !cap_fall_o && !pad_out_o
      && !pad_oe_o && !write_strobe_seen_o && gear_data_o == 4'h0)
      else $error("set/reset left a register set");
   a_ce_holds: assert property (!cell_ce_i && !lsr_i
      |=> $stable({cap_rise_o, cap_fall_o, gear_data_o, pad_out_o, pad_oe_o}))
      else $error("register moved with enable low");
   // six cycles covers sync, edge detect and update, yet ends before the next edge lands
   a_sdr_rise_zero: assert property ($rose(sys_clk_i) ##0
      (run_ok && cfg_i.mode == MODE_SDR)[*6] |-> !cap_rise_o)
      else $error("cap_rise set in single rate mode");
   a_rise_drives_out: assert property (($rose(sys_clk_i) && run_ok) ##1
      (run_ok && $stable({out_d_a_i, tri_in_i}))[*6]
      |-> pad_out_o == out_d_a_i && pad_oe_o == !tri_in_i)
      else $error("pad_out or pad_oe wrong after rise");
   a_fall_drives_out: assert property (($fell(sys_clk_i) && run_ok && ddr_on) ##1
      (run_ok && ddr_on && $stable(out_d_b_i))[*6] |-> pad_out_o == out_d_b_i)
      else $error("pad_out wrong after fall");
   a_flag_sticky: assert property (write_strobe_seen_o && !lsr_i |=> write_strobe_seen_o)
      else $error("strobe flag dropped");
   a_gear_quiet: assert property ($changed(gear_data_o) |-> $past(lsr_i) || $past(sys_clk_i, 3))
      else $error("gear word moved without a system clock rise");

   c_ddr_rise: cover property ($rose(sys_clk_i) && ddr_on);
   c_lsr_no_ce: cover property (lsr_i && !cell_ce_i);
   c_gear_change: cover property ($changed(gear_data_o));
endmodule

bind io_cell io_cell_sva sva_u (
   .mclk_i, .reset_i, .pad_i, .sys_clk_i, .cfg_i, .cell_ce_i, .lsr_i, .out_d_a_i,
   .out_d_b_i, .tri_in_i, .comb_in_o, .bypass_clk_o, .cap_rise_o, .cap_fall_o,
   .gear_data_o, .pad_out_o, .pad_oe_o, .write_strobe_seen_o
);

// *** verification/io_cell_src_model.sv ***
// partner model: source-synchronous sender driving pad, clocks and strobes
`timescale 1ns/100ps
module io_cell_src_model (
   output logic pad_o,
   output logic sys_clk_o,
   output logic edge_clk_o,
   output logic read_strobe_90_o,
   output logic write_strobe_90_o
);
   initial begin
      {pad_o, sys_clk_o, edge_clk_o, read_strobe_90_o, write_strobe_90_o} = 5'h00;
   end

   // one 160 ns period: r holds 40 ns either side of the rise, f around the fall;
   // strobes lead the clock by 20 ns so they land inside the data eye
   task automatic beat(input logic use_edge, input logic r, input logic f);
      pad_o = r;
      #20;
      {read_strobe_90_o, write_strobe_90_o} = 2'h3;
      #20;
      if (use_edge) edge_clk_o = 1'b1;
      else sys_clk_o = 1'b1;
      #40;
      pad_o = f;
      #20;
      {read_strobe_90_o, write_strobe_90_o} = 2'h0;
      #20;
      if (use_edge) edge_clk_o = 1'b0;
      else sys_clk_o = 1'b0;
      #40;
   endtask

   // clocks stand still between frames; the inverted pad shows no stale level
   task automatic idle;
      pad_o = ~pad_o;
   endtask
endmodule

// *** verification/test_io_cell.sv ***
// self-checking bench for the io cell capture and output paths
`timescale 1ns/100ps
module test_io_cell;
   import io_cell_pkg::*;
   logic              mclk_i, reset_i, pad_i, sys_clk_i, edge_clk_i, read_strobe_90_i;
   logic              write_strobe_90_i, sync_clk_polarity_i, cell_ce_i, lsr_i, update_i;
   logic              align_select_i, out_d_a_i, out_d_b_i, tri_in_i, comb_in_o, bypass_clk_o;
   logic              cap_rise_o, cap_fall_o, pad_out_o, pad_oe_o, write_strobe_seen_o;
   logic [GEAR_W-1:0] gear_data_o;
   logic              left_cap_rise, left_cap_fall, left_strobe_seen;
   cell_cfg_t         cfg_i;
   int                n_errors, n_tests;
   integer            seed;

   io_cell #(.CELL_EDGE(EDGE_RIGHT)) dut_u (
      .mclk_i, .reset_i, .pad_i, .sys_clk_i, .edge_clk_i, .read_strobe_90_i,
      .write_strobe_90_i, .sync_clk_polarity_i, .cfg_i, .cell_ce_i, .lsr_i, .update_i,
      .align_select_i, .out_d_a_i, .out_d_b_i, .tri_in_i, .comb_in_o, .bypass_clk_o,
      .cap_rise_o, .cap_fall_o, .gear_data_o, .pad_out_o, .pad_oe_o, .write_strobe_seen_o
   );
   // a left-edge cell has no strobe inputs, so memory mode must fall back to sdr
   io_cell #(.CELL_EDGE(EDGE_LEFT)) left_u (
      .mclk_i, .reset_i, .pad_i, .sys_clk_i, .edge_clk_i, .read_strobe_90_i,
      .write_strobe_90_i, .sync_clk_polarity_i, .cfg_i, .cell_ce_i, .lsr_i, .update_i,
      .align_select_i, .out_d_a_i, .out_d_b_i, .tri_in_i, .comb_in_o(), .bypass_clk_o(),
      .cap_rise_o(left_cap_rise), .cap_fall_o(left_cap_fall), .gear_data_o(), .pad_out_o(),
      .pad_oe_o(), .write_strobe_seen_o(left_strobe_seen)
   );
   io_cell_src_model src_u (
      .pad_o(pad_i), .sys_clk_o(sys_clk_i), .edge_clk_o(edge_clk_i),
      .read_strobe_90_o(read_strobe_90_i), .write_strobe_90_o(write_strobe_90_i)
   );

   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tick;
      @(posedge mclk_i);
      #2;
   endtask

   function automatic logic [1:0] cap_exp(input in_mode_t m, input logic [1:0] prev,
                                          input logic [1:0] cur, input logic dly);
      // the fixed delay outlasts the lead of data over the clock rise,
      // so a delayed sdr capture takes the fall half of the beat before
      if (m == MODE_SDR) return {1'b0, dly ? cur[0] : cur[1]};
      if (m == MODE_DDR || m == MODE_MEM) return prev;
      return 2'b00;
   endfunction

   // grouped runs hold one pair for four beats, so only the settled result is judged
   task automatic run_mode(input in_mode_t m, input logic dly, input int n);
      logic [1:0] prev, cur;
      logic [3:0] s, e;
      logic       grp;
      grp = dly || m == MODE_MEM;
      prev = 2'b00;
      cur = 2'b00;
      tick();
      cfg_i = '{mode: m, delay_en: dly, dyn_en: 1'($random(seed)), dyn_delay: 5'($random(seed))};
      for (int i = 0; i < n; i++) begin
         if (!grp || i % 4 == 0) begin
            cur = 2'($random(seed));
            sync_clk_polarity_i = 1'($random(seed));
         end
         src_u.beat(1'b0, cur[1], cur[0]);
         s = {comb_in_o, bypass_clk_o, cap_rise_o, cap_fall_o};
         e = {cur[0], cur[0], cap_exp(m, prev, cur, dly)};
         if (i > 0 && (!grp || i % 4 == 3)) check(s, e, "capture");
         if (m == MODE_MEM && i % 4 == 3) begin
            check({2'h0, left_cap_rise, left_cap_fall}, {3'h0, cur[1]}, "left edge");
         end
         prev = cur;
      end
      src_u.idle();
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   initial begin
      #200000;
      n_errors++;
      conclude();
   end

   initial begin
      logic [3:0] w;
      logic [1:0] hold;
      seed = 32'h3e78ad6d;
      n_errors = 0;
      n_tests = 0;
      reset_i = 1'b1;
      cfg_i = '{mode: MODE_BYPASS, delay_en: 1'b0, dyn_en: 1'b0, dyn_delay: 5'h00};
      {sync_clk_polarity_i, lsr_i, update_i, align_select_i, out_d_a_i, out_d_b_i} = 6'h00;
      {cell_ce_i, tri_in_i} = 2'h3;
      repeat (2) @(posedge mclk_i);
      #2 reset_i = 1'b0;
      repeat (3) tick();
      check(4'(write_strobe_seen_o), 4'h0, "strobe flag");
      run_mode(MODE_BYPASS, 1'b0, 6);
      run_mode(MODE_SDR, 1'b0, 12);
      run_mode(MODE_SDR, 1'b1, 8);
      run_mode(MODE_MEM, 1'b0, 16);
      run_mode(MODE_DDR, 1'b0, 12);
      check(4'(write_strobe_seen_o), 4'h1, "strobe flag");
      check(4'(left_strobe_seen), 4'h0, "left strobe flag");
      for (int i = 0; i < 6; i++) begin
         tick();
         {out_d_a_i, out_d_b_i, tri_in_i} = 3'($random(seed));
         fork
            src_u.beat(1'b0, 1'b0, 1'b1);
            begin
               #140;
               check(4'({pad_out_o, pad_oe_o}), 4'({out_d_a_i, ~tri_in_i}), "out rise");
               #80;
               check(4'(pad_out_o), 4'(out_d_b_i), "out fall");
            end
         join
      end
      hold = {cap_rise_o, cap_fall_o};
      tick();
      cell_ce_i = 1'b0;
      repeat (2) src_u.beat(1'b0, ~hold[1], ~hold[0]);
      check(4'({cap_rise_o, cap_fall_o}), 4'(hold), "enable hold");
      tick();
      lsr_i = 1'b1;
      tick();
      lsr_i = 1'b0;
      check({cap_rise_o, cap_fall_o, pad_out_o, write_strobe_seen_o}, 4'h0, "set/reset");
      cell_ce_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         tick();
         cfg_i.mode = MODE_GEAR;
         align_select_i = 1'($random(seed));
         w = 4'($random(seed));
         repeat (2) begin
            src_u.beat(1'b1, w[3], w[2]);
            src_u.beat(1'b1, w[1], w[0]);
         end
         repeat (4) tick();
         update_i = 1'b1;
         tick();
         update_i = 1'b0;
         src_u.beat(1'b0, 1'b0, 1'b0);
         check(gear_data_o, align_select_i ? {w[0], w[3:1]} : w, "gear");
      end
      conclude();
   end
endmodule
